// ==== verilog/itc_pkg.sv ====
// package: register map, field layout and timing constants of the integration timing control
package itc_pkg;
	// register addresses on the register port
	localparam logic [4:0] ITC_ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ITC_ADDR_TIMING = 5'h01;
	// control register bit positions
	localparam int ITC_CTL_POWER_BIT = 0;
	localparam int ITC_CTL_EN_BIT = 1;
	localparam int ITC_CTL_VALID_BIT = 4;
	localparam logic [7:0] ITC_TIMING_RESET = 8'h00;
	// integration mode select encodings
	localparam logic [1:0] ITC_MODE_FREE = 2'h0;
	localparam logic [1:0] ITC_MODE_MANUAL = 2'h1;
	localparam logic [1:0] ITC_MODE_ONESHOT = 2'h2;
	localparam logic [1:0] ITC_MODE_ACCUM = 2'h3;
	// nominal time codes and the largest pulse count code
	localparam logic [3:0] ITC_CODE_12MS = 4'h0;
	localparam logic [3:0] ITC_CODE_100MS = 4'h1;
	localparam logic [3:0] ITC_CODE_400MS = 4'h2;
	localparam logic [3:0] ITC_CODE_MAX_PULSE = 4'h8;
	localparam logic [8:0] ITC_PULSE_ONE = 9'h001;
	localparam logic [8:0] ITC_PULSE_MAX = 9'h100;
	// clock and time figures
	localparam int ITC_CLK_MHZ = 125;
	localparam int ITC_CLK_PERIOD_NS = 8;
	localparam int ITC_NOM_12MS_US = 12000;
	localparam int ITC_NOM_100MS_US = 100000;
	localparam int ITC_NOM_400MS_US = 400000;
	localparam int ITC_NOM_12MS_CYC = ITC_NOM_12MS_US * ITC_CLK_MHZ;
	localparam int ITC_NOM_100MS_CYC = ITC_NOM_100MS_US * ITC_CLK_MHZ;
	localparam int ITC_NOM_400MS_CYC = ITC_NOM_400MS_US * ITC_CLK_MHZ;
	// start delay after the trigger, least time so rounded up
	localparam int ITC_SYNC_DELAY_NS = 2400;
	localparam int ITC_SYNC_DELAY_CYC = (ITC_SYNC_DELAY_NS + ITC_CLK_PERIOD_NS - 1) / ITC_CLK_PERIOD_NS;
	localparam int ITC_CNT_W = 26;

	// timing register layout
	typedef struct packed {
		logic reserved;
		logic sync_edge_rise;
		logic [1:0] integration_mode_select;
		logic [3:0] time_or_count_code;
	} itc_timing_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} itc_req_t;
endpackage : itc_pkg

// ==== verilog/itc_top.sv ====
// module: integration timing control with its control and timing registers
`timescale 1ns/1ns
module itc_top #(
	parameter int NOM_12MS_CYC = itc_pkg::ITC_NOM_12MS_CYC,
	parameter int NOM_100MS_CYC = itc_pkg::ITC_NOM_100MS_CYC,
	parameter int NOM_400MS_CYC = itc_pkg::ITC_NOM_400MS_CYC
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// register port
	input wire itc_pkg::itc_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// external trigger pin
	input wire logic sync_in,
	// converter channel control
	output logic integrating,
	output logic cycle_done
);
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_INTEG} itc_state_t;

	itc_state_t st_q, st_d;
	itc_pkg::itc_timing_t timing_q;
	logic power_q;
	logic en_q;
	logic valid_q;
	logic sync_prev_q;
	logic [itc_pkg::ITC_CNT_W-1:0] cnt_q, cnt_d, nom_c;
	logic [8:0] pulse_q, pulse_d, target_c;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic done_q;
	logic end_c;
	logic run_c;
	logic rise_c;
	logic fall_c;
	logic stop_edge_c;
	logic ctl_wr_c;
	logic [1:0] mode_c;

	////////////////////////////////////////////////////////////////////////////////
	// register port
	assign ctl_wr_c = reg_req.wr && reg_req.addr == itc_pkg::ITC_ADDR_CONTROL;
	assign mode_c = timing_q.integration_mode_select;
	assign run_c = power_q && en_q;

	// control and timing writes; reserved timing bit kept at zero
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			power_q <= 1'b0;
			en_q <= 1'b0;
			timing_q <= itc_pkg::ITC_TIMING_RESET;
		end
		else if (clk_en && reg_req.wr)
		begin
			if (reg_req.addr == itc_pkg::ITC_ADDR_CONTROL)
			begin
				power_q <= reg_req.wdata[itc_pkg::ITC_CTL_POWER_BIT];
				en_q <= reg_req.wdata[itc_pkg::ITC_CTL_EN_BIT];
			end
			else if (reg_req.addr == itc_pkg::ITC_ADDR_TIMING)
			begin
				timing_q <= {1'b0, reg_req.wdata[6:0]};
			end
		end
	end

	// valid flag: a completing cycle wins over the clear by a control write
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			valid_q <= 1'b0;
		else if (clk_en)
		begin
			if (end_c)
				valid_q <= 1'b1;
			else if (ctl_wr_c)
				valid_q <= 1'b0;
		end
	end

	// registered read data, unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rvalid_q <= reg_req.rd;
			if (reg_req.rd)
			begin
				rdata_q <= 8'h00;
				if (reg_req.addr == itc_pkg::ITC_ADDR_CONTROL)
				begin
					rdata_q[itc_pkg::ITC_CTL_POWER_BIT] <= power_q;
					rdata_q[itc_pkg::ITC_CTL_EN_BIT] <= en_q;
					rdata_q[itc_pkg::ITC_CTL_VALID_BIT] <= valid_q;
				end
				else if (reg_req.addr == itc_pkg::ITC_ADDR_TIMING)
					rdata_q <= timing_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trigger edges; pin is synchronous so one flop is enough
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			sync_prev_q <= 1'b0;
		else if (clk_en)
			sync_prev_q <= sync_in;
	end

	assign rise_c = sync_in && !sync_prev_q;
	assign fall_c = !sync_in && sync_prev_q;
	assign stop_edge_c = timing_q.sync_edge_rise ? rise_c : fall_c;

	// nominal time; reserved codes fall back to the shortest time
	always_comb
	begin
		unique case (timing_q.time_or_count_code)
			itc_pkg::ITC_CODE_100MS: nom_c = itc_pkg::ITC_CNT_W'(NOM_100MS_CYC);
			itc_pkg::ITC_CODE_400MS: nom_c = itc_pkg::ITC_CNT_W'(NOM_400MS_CYC);
			default: nom_c = itc_pkg::ITC_CNT_W'(NOM_12MS_CYC);
		endcase
	end

	// pulse count, reserved codes saturate at the largest count
	assign target_c = (timing_q.time_or_count_code > itc_pkg::ITC_CODE_MAX_PULSE) ? itc_pkg::ITC_PULSE_MAX :
		(itc_pkg::ITC_PULSE_ONE << timing_q.time_or_count_code);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer; mode changes while running are the host's hazard
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		pulse_d = pulse_q;
		end_c = 1'b0;
		if (!run_c)
		begin
			st_d = ST_IDLE;
			cnt_d = '0;
			pulse_d = '0;
			end_c = (st_q == ST_INTEG);
		end
		else
		begin
			unique case (st_q)
				ST_IDLE:
				begin
					cnt_d = '0;
					pulse_d = '0;
					if (mode_c != itc_pkg::ITC_MODE_ONESHOT)
						st_d = ST_INTEG;
					else if (rise_c)
						st_d = ST_DELAY;
				end
				ST_DELAY:
				begin
					if (cnt_q == itc_pkg::ITC_CNT_W'(itc_pkg::ITC_SYNC_DELAY_CYC - 1))
					begin
						cnt_d = '0;
						st_d = ST_INTEG;
					end
					else
						cnt_d = cnt_q + 1'b1;
				end
				ST_INTEG:
				begin
					unique case (mode_c)
						itc_pkg::ITC_MODE_FREE, itc_pkg::ITC_MODE_ONESHOT:
						begin
							if (cnt_q == nom_c - 1'b1)
							begin
								end_c = 1'b1;
								cnt_d = '0;
								if (mode_c == itc_pkg::ITC_MODE_ONESHOT)
									st_d = ST_IDLE;
							end
							else
								cnt_d = cnt_q + 1'b1;
						end
						itc_pkg::ITC_MODE_MANUAL:
							st_d = ST_INTEG;
						itc_pkg::ITC_MODE_ACCUM:
						begin
							if (stop_edge_c)
							begin
								if (pulse_q == target_c - 1'b1)
								begin
									end_c = 1'b1;
									pulse_d = '0;
									st_d = ST_IDLE;
								end
								else
									pulse_d = pulse_q + 1'b1;
							end
						end
					endcase
				end
			endcase
		end
	end

	// sequencer state, counters and completion pulse
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			pulse_q <= '0;
			done_q <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
			done_q <= end_c;
		end
	end

	assign integrating = (st_q == ST_INTEG);
	assign cycle_done = done_q;
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	AST_ENABLE_START: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		$rose(run_c) && mode_c != itc_pkg::ITC_MODE_ONESHOT && $stable(mode_c) |-> ##2 integrating)
		else $error("channels did not start after enable");
	AST_DISABLE_STOP: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		!run_c |=> !integrating)
		else $error("channels still integrating after disable");
	AST_MANUAL_END: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		mode_c == itc_pkg::ITC_MODE_MANUAL && integrating && !run_c |=> !integrating && valid_q && cycle_done)
		else $error("manual stop did not complete a cycle");
	AST_MANUAL_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		mode_c == itc_pkg::ITC_MODE_MANUAL && integrating && run_c |=> integrating)
		else $error("manual integration ended without the host");
	AST_VALID_SET: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		cycle_done |-> valid_q)
		else $error("valid flag missing after completed cycle");
	AST_FREE_RESTART: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		end_c && run_c && mode_c == itc_pkg::ITC_MODE_FREE |=> integrating && cnt_q == '0)
		else $error("free-running cycle did not restart");
	AST_ONESHOT_DELAY: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		st_q == ST_IDLE && run_c && mode_c == itc_pkg::ITC_MODE_ONESHOT && rise_c ##1 run_c |-> (st_q == ST_DELAY)[*8])
		else $error("trigger start delay too short");
	AST_ONESHOT_START: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		$rose(integrating) && $past(st_q) == ST_DELAY |-> $past(cnt_q) == itc_pkg::ITC_CNT_W'(itc_pkg::ITC_SYNC_DELAY_CYC - 1))
		else $error("trigger start delay not kept");
	AST_EDGE_FALL: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		integrating && run_c && mode_c == itc_pkg::ITC_MODE_ACCUM && !timing_q.sync_edge_rise && !fall_c
		|=> pulse_q == $past(pulse_q) && integrating)
		else $error("accumulation counted a non-falling edge");
	AST_EDGE_RISE: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		integrating && run_c && mode_c == itc_pkg::ITC_MODE_ACCUM && timing_q.sync_edge_rise && !rise_c
		|=> pulse_q == $past(pulse_q) && integrating)
		else $error("accumulation counted a non-rising edge");
	AST_ACCUM_END: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
		cycle_done && $past(mode_c) == itc_pkg::ITC_MODE_ACCUM && $past(run_c) |-> $past(pulse_q) == $past(target_c) - 1'b1)
		else $error("accumulation ended at wrong pulse count");
endmodule : itc_top

// ==== verification/itc_sync_src.sv ====
// model: pulsed light source controller driving the trigger pin
`timescale 1ns/1ns
module itc_sync_src (
	// clock
	input wire logic ref_clk,
	// trigger pin
	output logic sync_in
);
	// idle low between pulses, so a rising edge always needs a fresh pulse
	initial sync_in = 1'b0;

	// hold a level for n cycles, changed just after each edge like a real driver
	task drive(input logic v, input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			#1;
			sync_in = v;
		end
	endtask : drive
endmodule : itc_sync_src

// ==== verification/integration_timing_control_tb.sv ====
// testbench: integration timing control driven by register writes and a trigger source
`timescale 1ns/1ns
module integration_timing_control_tb;
	// short nominal counts keep the run small
	localparam int LIMIT = 12000;
	localparam int NOM_12 = 20;
	localparam int NOM_100 = 40;
	localparam int NOM_400 = 80;
	logic ref_clk, resetn, clk_en, integrating, cycle_done, reg_rvalid, sync_in;
	logic [7:0] reg_rdata, rv;
	itc_pkg::itc_req_t reg_req;
	int err_count, checks, cyc, dcnt, d0, t0, dn;

	////////////////////////////////////////////////////////////////////////////////
	itc_top #(.NOM_12MS_CYC(NOM_12), .NOM_100MS_CYC(NOM_100), .NOM_400MS_CYC(NOM_400)) i_itc_top (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.sync_in(sync_in), .integrating(integrating), .cycle_done(cycle_done));
	itc_sync_src i_itc_sync_src (.ref_clk(ref_clk), .sync_in(sync_in));

	// 125 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// cycle count, completion count and hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cycle_done === 1'b1)
			dcnt++;
		if (cyc == LIMIT)
		begin
			err_count++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task end_sim;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// sample just after an edge so registered outputs have settled
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_req = {1'b1, 1'b0, a, d};
		step(1);
		reg_req = '0;
	endtask : wr

	task rd(input logic [4:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		reg_req = {1'b0, 1'b1, a, 8'h00};
		step(1);
		reg_req = '0;
		while (reg_rvalid !== 1'b1 && n < 4)
		begin
			step(1);
			n++;
		end
		// extra waits for the read answer, left in dn
		dn = n;
		d = reg_rdata;
	endtask : rd

	// bounded wait for the next completion pulse, cycles left in dn
	task wait_done;
		dn = 0;
		do
		begin
			step(1);
			dn++;
		end
		while (cycle_done !== 1'b1 && dn < 2000);
	endtask : wait_done

	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		rd(5'h00, rv);
		chk(rv, 8'h00);
		chk(dn, 0);
		rd(5'h01, rv);
		chk(rv, 8'h00);
		wr(5'h01, 8'h78);
		rd(5'h01, rv);
		chk(rv, 8'h78);
		wr(5'h00, 8'h10);
		rd(5'h00, rv);
		chk(rv, 8'h00);
		wr(5'h05, 8'haa);
		rd(5'h05, rv);
		chk(rv, 8'h00);
		wr(5'h01, 8'h00);
	endtask : t_regs

	task t_free;
		for (int c = 0; c < 3; c++)
		begin
			wr(5'h01, {4'h0, c[3:0]});
			wr(5'h00, 8'h03);
			wait_done();
			wait_done();
			chk(dn, (c == 0) ? NOM_12 : (c == 1) ? NOM_100 : NOM_400);
			chk(integrating, 1'b1);
			rd(5'h00, rv);
			chk(rv, 8'h13);
			wr(5'h00, 8'h00);
			step(3);
			chk(integrating, 1'b0);
		end
	endtask : t_free

	task t_manual;
		wr(5'h01, 8'h10);
		wr(5'h00, 8'h03);
		step(2);
		chk(integrating, 1'b1);
		d0 = dcnt;
		step(100);
		chk(dcnt - d0, 0);
		// a frozen block must not take the host's stop
		clk_en = 1'b0;
		wr(5'h00, 8'h00);
		step(3);
		chk(integrating, 1'b1);
		clk_en = 1'b1;
		wr(5'h00, 8'h00);
		step(1);
		chk(cycle_done, 1'b1);
		chk(integrating, 1'b0);
	endtask : t_manual

	task t_oneshot;
		wr(5'h01, 8'h20);
		wr(5'h00, 8'h03);
		step(2);
		chk(integrating, 1'b0);
		i_itc_sync_src.drive(1'b1, 1);
		t0 = cyc;
		i_itc_sync_src.drive(1'b0, 5);
		while (integrating !== 1'b1 && cyc - t0 < 400)
			step(1);
		chk(cyc - t0, 301);
		t0 = cyc;
		while (integrating === 1'b1 && cyc - t0 < 400)
			step(1);
		chk(cyc - t0, 20);
		d0 = dcnt;
		step(50);
		chk(dcnt - d0, 1);
		wr(5'h00, 8'h00);
	endtask : t_oneshot

	// the last pulse splits the rising and falling edge to tell the polarities apart
	task t_accum(input logic pol, input logic [3:0] code);
		wr(5'h01, {1'b0, pol, 2'b11, code});
		wr(5'h00, 8'h03);
		step(3);
		d0 = dcnt;
		repeat ((1 << code) - 1)
		begin
			i_itc_sync_src.drive(1'b1, 4);
			i_itc_sync_src.drive(1'b0, 4);
		end
		i_itc_sync_src.drive(1'b1, 4);
		chk(dcnt - d0, pol);
		i_itc_sync_src.drive(1'b0, 4);
		chk(dcnt - d0, 1);
		wr(5'h00, 8'h00);
		step(3);
	endtask : t_accum

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		clk_en = 1'b1;
		reg_req = '0;
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_regs();
		t_free();
		t_manual();
		t_oneshot();
		for (int p = 0; p < 2; p++)
		begin
			t_accum(p[0], 4'h0);
			t_accum(p[0], 4'h1);
			t_accum(p[0], 4'h8);
		end
		end_sim();
	end
endmodule : integration_timing_control_tb
